/* File: rtl/trig_cal_pkg.sv */
// Notes on behaviour
// [RULE1] calibration request zeroes both coarse codes and grounds both probe tips
// [RULE2] coarse code spans -9.99 V to +9.99 V in 10 mV steps
// [RULE3] fine code spans +75 mV to -75 mV in 1 mV steps, code zero is +75 mV
// [RULE4] rising-edge calibration starts with coarse and fine codes both at zero
// [RULE5] rising edge: fine steps down 1 mV until the comparator first toggles
// [RULE6] found fine code is kept and applied together with the selected coarse code
// [RULE7] falling edge: scan starts at -75 mV and steps upward until toggle
// [RULE8] level monitor shows coarse level plus stored fine offset of chosen channel
// [RULE9] controller recalibrates after power-up and after probe or edge changes; the code only raises cal_stale_out and does not start a calibration
// [RULE10] ten millivolt settings come from manual selectors or the remote bus
// [RULE11] probe, edge, polarity, level and calibration are all remotely controllable
// [RULE12] scan reaching the far end without a toggle stops and flags failure
package trig_cal_pkg;

  localparam int                 NUM_CH         = 2;
  localparam logic signed [10:0] COARSE_MAX     = 11'sh3e7;
  localparam logic signed [10:0] COARSE_MIN     = -11'sh3e7;
  localparam logic signed [10:0] COARSE_ZERO    = 11'sh000;
  localparam logic signed [15:0] MV_PER_COARSE  = 16'sh000a;
  localparam logic signed [15:0] FINE_SPAN_MV   = 16'sh004b;
  localparam logic [7:0]         FINE_TOP_CODE  = 8'h00;
  localparam logic [7:0]         FINE_BOT_CODE  = 8'h96;
  localparam logic [7:0]         FINE_STEP      = 8'h01;
  localparam int                 CLK_PERIOD_NS  = 50;
  localparam int                 SETTLE_NS      = 1000;
  localparam int                 SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0]         SETTLE_LOAD    = 5'(SETTLE_CYC - 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOAD = 3'b010,
    ST_SCAN = 3'b100
  } cal_state_t;

  // one channel's user settings
  typedef struct packed {
    logic signed [10:0] level;
    logic               falling;
    logic               probe_b;
    logic               invert;
  } chan_cfg_t;

  typedef struct packed {
    chan_cfg_t [NUM_CH-1:0] ch;
    logic                   cal;
    logic                   mon_sel;
  } ctrl_t;

endpackage : trig_cal_pkg

/* File: rtl/trigger_level_calibration.sv */
`timescale 1ns/1ps
module trigger_level_calibration (
  // clock and reset
  input  wire logic                             mclk_in,
  input  wire logic                             reset_n_in,
  // settings from the panel selectors and from the remote bus
  input  wire trig_cal_pkg::ctrl_t              manual_ctrl_in,
  input  wire trig_cal_pkg::ctrl_t              remote_ctrl_in,
  input  wire logic                             remote_sel_in,
  // analog comparators, one per channel
  input  wire logic [1:0]                       comp_in,
  // converter codes and analog controls
  output logic signed [1:0][10:0]               coarse_code_out,
  output logic [1:0][7:0]                       fine_code_out,
  output logic [1:0]                            probe_b_out,
  output logic [1:0]                            falling_out,
  output logic [1:0]                            invert_out,
  output logic                                  probe_ground_out,
  // status and level monitor
  output logic                                  cal_busy_out,
  output logic [1:0]                            cal_fail_out,
  output logic                                  cal_stale_out,
  output logic signed [15:0]                    monitor_mv_out
);
  import trig_cal_pkg::*;

  typedef struct packed {
    cal_state_t                   fsm;
    logic [4:0]                   settle;
    logic [NUM_CH-1:0]            comp_s1;
    logic [NUM_CH-1:0]            comp_s2;
    ctrl_t                        man_s1;
    ctrl_t                        man_s2;
    ctrl_t                        cfg;
    logic                         cal_prev;
    logic [NUM_CH-1:0]            init_comp;
    logic [NUM_CH-1:0]            done;
    logic [NUM_CH-1:0]            fail;
    logic [NUM_CH-1:0][7:0]       fine;
    logic [NUM_CH-1:0][1:0]       snap;
    logic                         stale;
    logic signed [NUM_CH-1:0][15:0] thr_mv;
  } state_t;

  state_t st_reg;
  state_t st_next;
  ctrl_t  active;
  logic   cal_pulse;

  always_comb begin
    st_next = st_reg;
    // both sync stages; only the second one is read by logic
    st_next.comp_s1 = comp_in;
    st_next.comp_s2 = st_reg.comp_s1;
    st_next.man_s1  = manual_ctrl_in;
    st_next.man_s2  = st_reg.man_s1;
    // [RULE10] manual or remote source
    // [RULE11] whole control set remote
    active = remote_sel_in ? remote_ctrl_in : st_reg.man_s2;
    st_next.cal_prev = active.cal;
    cal_pulse = active.cal & ~st_reg.cal_prev;
    // [RULE2] clamp coarse range
    for (int i = 0; i < NUM_CH; i++) begin
      if (active.ch[i].level > COARSE_MAX) begin
        active.ch[i].level = COARSE_MAX;
      end else if (active.ch[i].level < COARSE_MIN) begin
        active.ch[i].level = COARSE_MIN;
      end
    end
    // settings are frozen while a scan runs so the edge choice cannot flip mid-scan
    if (st_reg.fsm == ST_IDLE) begin
      st_next.cfg = active;
    end
    case (st_reg.fsm)
      ST_IDLE: begin
        if (cal_pulse) begin
          st_next.fsm    = ST_LOAD;
          st_next.settle = SETTLE_LOAD;
          st_next.done   = '0;
          st_next.fail   = '0;
          // [RULE4] rising start at top
          // [RULE7] falling start at bottom
          for (int i = 0; i < NUM_CH; i++) begin
            st_next.fine[i] = active.ch[i].falling ? FINE_BOT_CODE : FINE_TOP_CODE;
          end
        end
      end
      ST_LOAD: begin
        st_next.settle = st_reg.settle - 5'h01;
        if (st_reg.settle == 5'h00) begin
          st_next.init_comp = st_reg.comp_s2;
          st_next.settle    = SETTLE_LOAD;
          st_next.fsm       = ST_SCAN;
        end
      end
      ST_SCAN: begin
        st_next.settle = st_reg.settle - 5'h01;
        if (st_reg.settle == 5'h00) begin
          st_next.settle = SETTLE_LOAD;
          for (int i = 0; i < NUM_CH; i++) begin
            if (!st_reg.done[i]) begin
              if (st_reg.comp_s2[i] != st_reg.init_comp[i]) begin
                st_next.done[i] = 1'b1;
              end else if (st_reg.fine[i] ==
                           (st_reg.cfg.ch[i].falling ? FINE_TOP_CODE : FINE_BOT_CODE)) begin
                // [RULE12] end reached, flag
                st_next.done[i] = 1'b1;
                st_next.fail[i] = 1'b1;
              end else if (st_reg.cfg.ch[i].falling) begin
                st_next.fine[i] = st_reg.fine[i] - FINE_STEP;
              end else begin
                // [RULE5] step down one mV
                st_next.fine[i] = st_reg.fine[i] + FINE_STEP;
              end
            end
          end
          if (&st_next.done) begin
            st_next.fsm   = ST_IDLE;
            st_next.stale = 1'b0;
            for (int i = 0; i < NUM_CH; i++) begin
              st_next.snap[i] = {st_reg.cfg.ch[i].falling, st_reg.cfg.ch[i].probe_b};
            end
          end
        end
      end
      default: begin
        st_next.fsm = ST_IDLE;
      end
    endcase
    // [RULE9] flag probe or edge choice changed since last calibration
    // compare against this cycle's snapshot, so the completing cycle leaves the flag clear
    for (int i = 0; i < NUM_CH; i++) begin
      if (st_next.fsm == ST_IDLE &&
          st_next.snap[i] != {st_next.cfg.ch[i].falling, st_next.cfg.ch[i].probe_b}) begin
        st_next.stale = 1'b1;
      end
    end
    // [RULE6] stored fine plus coarse
    // [RULE8] monitor sum
    for (int i = 0; i < NUM_CH; i++) begin
      st_next.thr_mv[i] = $signed({{5{st_next.cfg.ch[i].level[10]}}, st_next.cfg.ch[i].level})
                          * MV_PER_COARSE + FINE_SPAN_MV
                          - $signed({8'h00, st_next.fine[i]});
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      st_reg       <= '0;
      st_reg.fsm   <= ST_IDLE;
      st_reg.stale <= 1'b1;
      // zero level, zero fine code: monitor already matches the idle formula
      st_reg.thr_mv <= {NUM_CH{FINE_SPAN_MV}};
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    cal_busy_out     = (st_reg.fsm != ST_IDLE);
    // [RULE1] ground tips during calibration
    probe_ground_out = cal_busy_out;
    cal_fail_out     = st_reg.fail;
    cal_stale_out    = st_reg.stale;
    fine_code_out    = st_reg.fine;
    monitor_mv_out   = st_reg.thr_mv[st_reg.cfg.mon_sel];
    for (int i = 0; i < NUM_CH; i++) begin
      // [RULE1] coarse forced to zero
      coarse_code_out[i] = cal_busy_out ? COARSE_ZERO : st_reg.cfg.ch[i].level;
      probe_b_out[i]     = st_reg.cfg.ch[i].probe_b;
      falling_out[i]     = st_reg.cfg.ch[i].falling;
      invert_out[i]      = st_reg.cfg.ch[i].invert;
    end
  end

  sequence cal_start_s;
    st_reg.fsm == ST_IDLE && cal_pulse;
  endsequence

  sequence load_rise_s;
    st_reg.fsm == ST_LOAD && fine_code_out[0] == FINE_TOP_CODE;
  endsequence

  AST_CAL_ZEROES: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RULE1]
    cal_start_s |=> probe_ground_out && coarse_code_out[0] == COARSE_ZERO
                    && coarse_code_out[1] == COARSE_ZERO)
    else $error("coarse not zeroed or probes not grounded");
  AST_COARSE_RANGE: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RULE2]
    $signed(coarse_code_out[0]) <= COARSE_MAX && $signed(coarse_code_out[0]) >= COARSE_MIN
    && $signed(coarse_code_out[1]) <= COARSE_MAX && $signed(coarse_code_out[1]) >= COARSE_MIN)
    else $error("coarse code outside range");
  AST_FINE_RANGE: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RULE3]
    fine_code_out[0] <= FINE_BOT_CODE && fine_code_out[1] <= FINE_BOT_CODE)
    else $error("fine code outside range");
  AST_RISE_START: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RULE4]
    cal_start_s ##0 !active.ch[0].falling |=> load_rise_s)
    else $error("rising scan did not start at zero code");
  AST_STEP_DOWN: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RULE5]
    st_reg.fsm == ST_SCAN && !st_reg.cfg.ch[0].falling && $changed(fine_code_out[0])
    |-> fine_code_out[0] == $past(fine_code_out[0]) + FINE_STEP)
    else $error("rising scan step wrong");
  AST_HOLD_FINE: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RULE6]
    !cal_busy_out ##1 !cal_busy_out |-> $stable(fine_code_out))
    else $error("stored fine code changed outside calibration");
  AST_FALL_START: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RULE7]
    cal_start_s ##0 active.ch[1].falling |=> fine_code_out[1] == FINE_BOT_CODE)
    else $error("falling scan did not start at bottom code");
  AST_MONITOR: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RULE8]
    !st_reg.cfg.mon_sel |-> monitor_mv_out == $signed({{5{st_reg.cfg.ch[0].level[10]}},
      st_reg.cfg.ch[0].level}) * MV_PER_COARSE + FINE_SPAN_MV
      - $signed({8'h00, fine_code_out[0]}))
    else $error("monitor does not match level plus offset");
  AST_FAIL_END: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RULE12]
    $rose(cal_fail_out[0]) |-> fine_code_out[0] ==
      (st_reg.cfg.ch[0].falling ? FINE_TOP_CODE : FINE_BOT_CODE))
    else $error("failure raised away from range end");
  AST_STEP_UP: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RULE7]
    st_reg.fsm == ST_SCAN && st_reg.cfg.ch[1].falling && $changed(fine_code_out[1])
    |-> fine_code_out[1] == $past(fine_code_out[1]) - FINE_STEP)
    else $error("falling scan step wrong");
  AST_FAIL_END_STOP: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // [RULE12]
    $rose(cal_fail_out[1]) |-> fine_code_out[1] ==
      (st_reg.cfg.ch[1].falling ? FINE_TOP_CODE : FINE_BOT_CODE))
    else $error("stop channel failure raised away from range end");

endmodule : trigger_level_calibration

/* File: test/comp_model.sv */
`timescale 1ns/1ps
module comp_model #(
  parameter int DLY_NS = 300
) (
  // converter codes and slope from the block
  input  wire logic [1:0][7:0] fine_code_in,
  input  wire logic [1:0]      falling_in,
  // code at which each grounded channel trips
  input  wire logic [1:0][7:0] trip_code_in,
  // comparator outputs
  output wire logic [1:0]      comp_out
);
  // inertial delay: the output lags each code change like a settling converter
  for (genvar i = 0; i < 2; i++) begin : g_ch
    assign #(DLY_NS) comp_out[i] = falling_in[i] ? (fine_code_in[i] <= trip_code_in[i])
                                                 : (fine_code_in[i] >= trip_code_in[i]);
  end
endmodule : comp_model

/* File: test/trigger_level_calibration_tb_top.sv */
`timescale 1ns/1ps
module trigger_level_calibration_tb_top;
  import trig_cal_pkg::*;
  logic                    mclk_in = 1'b0;
  logic                    reset_n_in = 1'b0;
  ctrl_t                   man_c = '0;
  ctrl_t                   rem_c = '0;
  logic                    rsel = 1'b1;
  logic [1:0]              comp, prb, fal, inv, fail;
  logic signed [1:0][10:0] coarse;
  logic [1:0][7:0]         fine;
  logic                    gnd, busy, stale;
  logic signed [15:0]      mon;
  logic [1:0][7:0]         trip = '0;
  logic [31:0]             seed = 32'h42;
  int                      error_cnt = 0;
  int                      checks_done = 0;

  always #25 mclk_in = ~mclk_in;

  trigger_level_calibration dut_u (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .manual_ctrl_in(man_c), .remote_ctrl_in(rem_c), .remote_sel_in(rsel), .comp_in(comp),
    .coarse_code_out(coarse), .fine_code_out(fine), .probe_b_out(prb), .falling_out(fal),
    .invert_out(inv), .probe_ground_out(gnd), .cal_busy_out(busy), .cal_fail_out(fail),
    .cal_stale_out(stale), .monitor_mv_out(mon));
  comp_model model_u (.fine_code_in(fine), .falling_in(fal), .trip_code_in(trip),
    .comp_out(comp));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic signed [10:0] clamp(input logic signed [10:0] v);
    return (v > COARSE_MAX) ? COARSE_MAX : ((v < COARSE_MIN) ? COARSE_MIN : v);
  endfunction : clamp

  task automatic check_val(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check_val

  task automatic print_verdict();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // every drive and sample lands 5 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #5;
  endtask : tick

  // level in coarse codes plus the fine offset, in millivolts
  function automatic logic [15:0] exp_mon(input logic signed [10:0] lv, input logic [7:0] fc);
    return 16'(lv) * MV_PER_COARSE + FINE_SPAN_MV - $signed({8'h0, fc});
  endfunction : exp_mon

  task automatic drive_ctrl(input logic sel, input ctrl_t c);
    if (sel) begin
      rem_c = c;
    end else begin
      man_c = c;
    end
  endtask : drive_ctrl

  task automatic run_cal(input logic sel, input logic [1:0] fl, input logic [1:0][7:0] tr,
                         input logic signed [1:0][10:0] lv, input logic ms);
    ctrl_t              c;
    int                 n;
    logic [7:0]         ef;
    logic [2:0]         sf;
    logic signed [15:0] em;
    c = ctrl_t'(30'(xs()));
    c.cal = 1'b0;
    c.mon_sel = ms;
    for (int i = 0; i < 2; i++) begin
      c.ch[i].level = lv[i];
      c.ch[i].falling = fl[i];
    end
    trip = tr;
    rsel = sel;
    drive_ctrl(sel, c);
    tick(4);
    c.cal = 1'b1;
    drive_ctrl(sel, c);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (busy !== 1'b1 && n < 8);
    // remote request is taken on the next edge, manual one waits for two sync flops
    check_val(16'(n), sel ? 16'h1 : 16'h3);
    check_val({15'h0, gnd}, 16'h1);
    for (int i = 0; i < 2; i++) begin
      ef = fl[i] ? FINE_BOT_CODE : FINE_TOP_CODE;
      check_val({5'h0, coarse[i]}, 16'h0);
      check_val({8'h0, fine[i]}, {8'h0, ef});
    end
    c.cal = 1'b0;
    drive_ctrl(sel, c);
    n = 0;
    while (busy === 1'b1 && n < 4000) begin
      tick(1);
      n++;
    end
    check_val({15'h0, n >= 4000}, 16'h0);
    tick(2);
    check_val({14'h0, gnd, busy}, 16'h0);
    em = '0;
    for (int i = 0; i < 2; i++) begin
      ef = (tr[i] == 8'hff) ? (fl[i] ? FINE_TOP_CODE : FINE_BOT_CODE) : tr[i];
      sf = {c.ch[i].probe_b, c.ch[i].invert, fl[i]};
      check_val({8'h0, fine[i]}, {8'h0, ef});
      check_val({15'h0, fail[i]}, {15'h0, tr[i] == 8'hff});
      check_val({5'h0, coarse[i]}, {5'h0, clamp(lv[i])});
      check_val({13'h0, prb[i], inv[i], fal[i]}, {13'h0, sf});
      if (i == int'(ms)) begin
        em = exp_mon(clamp(lv[i]), ef);
      end
    end
    check_val(mon, em);
    if (tr[0] != 8'hff && tr[1] != 8'hff) begin
      check_val({15'h0, stale}, 16'h0);
    end
  endtask : run_cal

  initial begin
    logic [1:0]              fl;
    logic [1:0][7:0]         tr;
    logic signed [1:0][10:0] lv;
    tick(5);
    reset_n_in = 1'b1;
    tick(1);
    check_val({15'h0, stale}, 16'h1);
    check_val(mon, exp_mon(COARSE_ZERO, FINE_TOP_CODE));
    for (int k = 0; k < 4; k++) begin
      fl = 2'(xs());
      for (int i = 0; i < 2; i++) begin
        tr[i] = 8'(xs() % 32'h96) + 8'(!fl[i]);
        lv[i] = 11'(xs() % 32'h7cf) - COARSE_MAX;
      end
      run_cal(k[1], fl, tr, lv, k[0]);
    end
    // both range ends reached with a toggle, then a scan with no toggle at all
    run_cal(1'b1, 2'b01, {8'h96, 8'h00}, {COARSE_MIN, COARSE_MAX}, 1'b1);
    run_cal(1'b1, 2'b10, {8'hff, 8'hff}, {11'h3ff, 11'h7fb}, 1'b0);
    run_cal(1'b0, 2'b11, {8'h40, 8'h05}, {11'h123, 11'h400}, 1'b1);
    man_c.ch[0].falling = 1'b0;
    tick(6);
    check_val({15'h0, stale}, 16'h1);
    print_verdict();
  end

  // seven scans of at most about 3100 cycles each, with ample margin
  initial begin
    #(40000 * CLK_PERIOD_NS);
    check_val(16'h1, 16'h0);
    print_verdict();
  end
endmodule : trigger_level_calibration_tb_top
